// ---- bench/rbo_core_model.sv ----
// Core memory model behind the overlay's core port.
`timescale 1ns/1ps
module rbo_core_model (
   input  wire        clock,
   input  wire        coreReq,
   input  wire        slow,
   input  wire [14:0] coreAddr,
   output reg         coreAck = 1'h0,
   output reg  [15:0] coreRdata = 16'h0000
);
   reg [2:0] waitQ = 3'h0; // Cycles spent on the current request.
   // Answer fast or slow; outside an answer the data lines toggle so stale data never matches.
   always @(posedge clock) begin
      coreAck <= 1'h0;
      coreRdata <= ~coreRdata;
      waitQ <= (coreReq && !coreAck) ? waitQ + 3'h1 : 3'h0;
      if (coreReq && !coreAck && waitQ >= (slow ? 3'h4 : 3'h0)) begin
         coreAck <= 1'h1;
         coreRdata <= {1'h1, coreAddr} ^ 16'h5A5A;
      end
   end
endmodule

// ---- bench/rbo_overlay_properties.sv ----
// Checker of panel start, fetch steering and the ROM read window.
`timescale 1ns/1ps
module rbo_overlay_properties (
   input wire        clock, rst_n, restartPresent, loadStartSwitch, stopSwitchUp, runMode,
   input wire        restartRequest, consoleInterrupt, overlayActive, cpuReq, cpuFetch,
   input wire        cpuWrite, cpuAck, cpuFromRom, wb_we_i, wb_ack_o,
   input wire [14:0] cpuAddr,
   input wire [15:0] cpuRdata,
   input wire [3:0]  wb_adr_i, wb_sel_i,
   input wire [31:0] wb_dat_i
);
   reg [1:0] ctlQ; // Mirror of the extended-end and full-core control bits.
   // Track control writes so the end address and window state are known here.
   always @(posedge clock) begin
      if (!rst_n) ctlQ <= 2'h0;
      else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0]) ctlQ <= wb_dat_i[1:0];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_run; $rose(loadStartSwitch) && runMode |=> consoleInterrupt && !restartRequest; endproperty
   a_run: assert property (p_run) else $error("no console interrupt");
   property p_go; $rose(loadStartSwitch) && stopSwitchUp && !runMode && restartPresent
      |=> restartRequest && overlayActive; endproperty
   a_go: assert property (p_go) else $error("no restart");
   property p_why; restartRequest |-> $past(stopSwitchUp) && !$past(runMode) && $past(restartPresent); endproperty
   a_why: assert property (p_why) else $error("restart without cause");
   property p_rom; overlayActive && cpuReq && !cpuAck && cpuFetch && cpuAddr < 15'h0080
      |-> ##[0:4] cpuAck && cpuFromRom; endproperty
   a_rom: assert property (p_rom) else $error("fetch not from ROM");
   property p_dat; cpuAck && !cpuFetch && cpuAddr < 15'h0080 |-> !cpuFromRom; endproperty
   a_dat: assert property (p_dat) else $error("data from ROM");
   property p_end; cpuAck && cpuFromRom && cpuFetch && cpuAddr == (ctlQ[0] ? 15'h007F : 15'h005F)
      |=> !overlayActive; endproperty
   a_end: assert property (p_end) else $error("overlay not ended");
   property p_aft; cpuAck && cpuFetch && cpuAddr < 15'h0080 && !$past(overlayActive, 3)
      |-> !cpuFromRom; endproperty
   a_aft: assert property (p_aft) else $error("ROM after end");
   property p_win; cpuAck && !cpuFetch && !cpuWrite && cpuAddr >= 15'h7000 && !ctlQ[1]
      |-> cpuFromRom && cpuRdata == {9'h000, cpuAddr[6:0]}; endproperty
   a_win: assert property (p_win) else $error("window read wrong");
   property p_full; cpuAck && cpuAddr >= 15'h7000 && ctlQ[1] |-> !cpuFromRom; endproperty
   a_full: assert property (p_full) else $error("window not disabled");
   c_go: cover property (restartRequest);
   c_int: cover property (consoleInterrupt);
   c_end: cover property ($fell(overlayActive));
endmodule
bind rbo_overlay rbo_overlay_properties u_rbo_overlay_properties (.clock, .rst_n,
   .restartPresent, .loadStartSwitch, .stopSwitchUp, .runMode, .restartRequest,
   .consoleInterrupt, .overlayActive, .cpuReq, .cpuFetch, .cpuWrite, .cpuAck, .cpuFromRom,
   .wb_we_i, .wb_ack_o, .cpuAddr, .cpuRdata, .wb_adr_i, .wb_sel_i, .wb_dat_i);

// ---- bench/testbench.sv ----
// Self-checking bench for the bootstrap overlay.
`timescale 1ns/1ps
module testbench;
   reg clock = 1'h0, rst_n = 1'h0, restartPresent = 1'h1, loadStartSwitch = 1'h0;
   reg stopSwitchUp = 1'h1, runMode = 1'h0, cpuReq = 1'h0, cpuFetch = 1'h0, slow = 1'h0;
   reg cpuWrite = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   reg cpuByteMode = 1'h0; // Word-mode reads only.
   reg [3:0] dataSwitchesDown = 4'h0, wb_adr_i = 4'h0, wb_sel_i = 4'hF;
   reg [14:0] cpuAddr = 15'h0000, ra;
   reg [31:0] wb_dat_i = 32'h0, r;
   wire restartRequest, consoleInterrupt, overlayActive, cpuAck, cpuFromRom;
   wire coreReq, coreWrite, coreAck, wb_ack_o;
   wire [2:0] loadDevice;
   wire [15:0] cpuRdata, coreRdata;
   wire [14:0] coreAddr;
   wire [31:0] wb_dat_o;
   integer err_count = 0, checks_done = 0, n;
   rbo_overlay u_rbo_overlay (.clock, .rst_n, .restartPresent, .loadStartSwitch, .stopSwitchUp,
      .runMode, .dataSwitchesDown, .restartRequest, .consoleInterrupt, .loadDevice,
      .overlayActive, .cpuReq, .cpuFetch, .cpuWrite, .cpuByteMode, .cpuAddr, .cpuAck,
      .cpuRdata, .cpuFromRom, .coreReq, .coreWrite, .coreAddr, .coreAck, .coreRdata,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
   rbo_core_model u_rbo_core_model (.clock, .coreReq, .slow, .coreAddr, .coreAck, .coreRdata);
   always #25 clock = ~clock;
   function [2:0] dev(input [3:0] s); // Lowest switch that is down wins.
      dev = s[0] ? 3'h1 : s[1] ? 3'h2 : s[2] ? 3'h3 : s[3] ? 3'h4 : 3'h0;
   endfunction
   function [15:0] cw(input [14:0] a); // Word the core model returns.
      cw = {1'h1, a} ^ 16'h5A5A;
   endfunction
   task chk(input [31:0] e, input [31:0] g);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks=%0d errors=%0d", checks_done, err_count);
         if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task tick(input d); // One edge of a bounded wait; running out ends the run.
      begin
         @(posedge clock);
         n = n + 1;
         if (!d && n > 40) begin
            err_count = err_count + 1;
            give_verdict;
         end
      end
   endtask
   task cpu(input f, input [14:0] a, input [15:0] e, input fr);
      begin
         cpuReq <= 1'h1;
         cpuFetch <= f;
         cpuAddr <= a;
         n = 0;
         do tick(cpuAck); while (!cpuAck);
         cpuReq <= 1'h0;
         chk(e, cpuRdata);
         chk(fr, cpuFromRom);
         @(posedge clock);
      end
   endtask
   task wb(input w, input [3:0] a, input [31:0] d, input [31:0] e);
      begin
         {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
         n = 0;
         do tick(wb_ack_o); while (!wb_ack_o);
         if (!w) chk(e, wb_dat_o);
         {wb_cyc_i, wb_stb_i} <= 2'h0;
         @(posedge clock);
      end
   endtask
   task press(input s, input rn, input p, input [3:0] sw);
      begin
         {stopSwitchUp, runMode, restartPresent, dataSwitchesDown} <= {s, rn, p, sw};
         @(posedge clock);
         loadStartSwitch <= 1'h1;
         repeat (2) @(posedge clock);
         chk(s && !rn && p, restartRequest);
         chk(rn, consoleInterrupt);
         if (s && !rn && p) chk(dev(sw), loadDevice);
         loadStartSwitch <= 1'h0;
         @(posedge clock);
      end
   endtask
   initial begin
      r = $urandom(97);
      repeat (4) @(posedge clock);
      rst_n <= 1'h1;
      @(posedge clock);
      wb(0, 4'h8, 0, 0);
      wb(1, 4'h8, 32'hFFFFFFFF, 0);
      wb(0, 4'h0, 0, 0);
      press(1, 0, 1, 4'h0);
      chk(1, overlayActive);
      wb(0, 4'h4, 0, 32'h3);
      cpu(1, 15'h0000, 16'h0000, 1);
      slow <= 1'h1;
      cpu(0, 15'h0010, cw(15'h0010), 0);
      repeat (4) begin
         ra = $urandom % 95;
         cpu(1, ra, {9'h000, ra[6:0]}, 1);
      end
      cpu(1, 15'h005F, 16'h005F, 1);
      chk(0, overlayActive);
      cpu(1, 15'h0010, cw(15'h0010), 0);
      cpu(0, 15'h7085, 16'h0005, 1);
      wb(1, 4'h0, 32'h3, 0);
      wb(0, 4'h0, 0, 32'h3);
      cpu(0, 15'h7085, cw(15'h7085), 0);
      press(1, 0, 1, 4'hC);
      cpu(1, 15'h005F, 16'h005F, 1);
      chk(1, overlayActive);
      cpu(1, 15'h007F, 16'h007F, 1);
      chk(0, overlayActive);
      press(1, 1, 1, 4'h0);
      press(0, 0, 1, 4'h1);
      press(1, 0, 0, 4'h8);
      repeat (24) begin
         r = $urandom;
         press(r[0], r[1], r[2], r[6:3]);
      end
      give_verdict;
   end
endmodule

// ---- verilog/rbo_consts.vh ----
// Constants for the ROM bootstrap overlay block.
// Overview of operation
// RQ1 - Load-start only when stopped and not running.
// RQ2 - Load-start while running raises console interrupt.
// RQ3 - Data switches choose loader input device.
// RQ4 - Entry runs restart: reset, PC zero, start.
// RQ5 - Overlay built only with power-up restart logic.
// RQ6 - Fetches from ROM, data cycles to core.
// RQ7 - Standard build ends overlay at ROM 005F.
// RQ8 - Extended build ends overlay at ROM 007F.
// RQ9 - Small core: reads at 7000+ return ROM.
// RQ10 - Software reads ROM window in word mode.
// RQ11 - Full 32K core disables ROM read window.
// RQ12 - No core locations reserved by the overlay.
// RQ13 - After end, low fetches go to core.
`ifndef RBO_CONSTS_VH
`define RBO_CONSTS_VH
`define RBO_ADDR_W 15
`define RBO_DATA_W 16
`define RBO_ROM_AW 7
`define RBO_END_STD 15'h005F
`define RBO_END_EXT 15'h007F
`define RBO_DIAG_BASE 15'h7000
`define RBO_DEV_TTY 3'h0
`define RBO_DEV_FASTPT 3'h1
`define RBO_DEV_MAGTAPE 3'h2
`define RBO_DEV_CASSETTE 3'h3
`define RBO_DEV_DISK 3'h4
`define RBO_WB_CTRL 4'h0
`define RBO_WB_STAT 4'h4
`define RBO_CTRL_EXT_BIT 0
`define RBO_CTRL_FULL_BIT 1
`define RBO_CTRL_RST 2'h0
`endif

// ---- verilog/rbo_overlay.v ----
// ROM bootstrap overlay: panel start, restart request, fetch steering, ROM window.
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "rbo_consts.vh"
module rbo_overlay #(
   parameter AW = `RBO_ADDR_W,  // Word address width.
   parameter DW = `RBO_DATA_W   // Data width.
) (
   input  wire          clock,
   input  wire          rst_n,
   input  wire          restartPresent,
   input  wire          loadStartSwitch,
   input  wire          stopSwitchUp,
   input  wire          runMode,
   input  wire [3:0]    dataSwitchesDown,
   output reg           restartRequest,
   output reg           consoleInterrupt,
   output reg  [2:0]    loadDevice,
   output wire          overlayActive,
   input  wire          cpuReq,
   input  wire          cpuFetch,
   input  wire          cpuWrite,
   input  wire          cpuByteMode,
   input  wire [AW-1:0] cpuAddr,
   output reg           cpuAck,
   output reg  [DW-1:0] cpuRdata,
   output reg           cpuFromRom,
   output wire          coreReq,
   output wire          coreWrite,
   output wire [AW-1:0] coreAddr,
   input  wire          coreAck,
   input  wire [DW-1:0] coreRdata,
   input  wire          wb_cyc_i,
   input  wire          wb_stb_i,
   input  wire          wb_we_i,
   input  wire [3:0]    wb_adr_i,
   input  wire [3:0]    wb_sel_i,
   input  wire [31:0]   wb_dat_i,
   output reg  [31:0]   wb_dat_o,
   output reg           wb_ack_o
);
   localparam ST_IDLE   = 2'h0;  // No memory cycle in progress.
   localparam ST_ROM    = 2'h1;  // Waiting for ROM read data.
   localparam ST_CORE   = 2'h2;  // Core cycle outstanding.
   localparam ST_ROMOUT = 2'h3;  // ROM word ready, acknowledge.

   reg  [1:0]  ctrl_q;          // Build options: extended end, full core.
   reg         active_q;        // Overlay in force.
   reg         loadPrev_q;      // Switch level last cycle for edge detect.
   reg  [1:0]  state_q;         // Memory cycle state.
   reg  [1:0]  state_d;         // Next memory cycle state.
   reg         isRom_q;         // Current cycle served from ROM.
   reg         endHit_q;        // Current fetch is the terminal instruction.
   reg  [AW-1:0] addr_q;        // Latched cycle address.
   wire [DW-1:0] romData;       // ROM read data.
   wire        loadPress;       // One-cycle press of the load-start switch.
   wire        extBuild;        // Extended termination address selected.
   wire        fullCore;        // Machine has 32K of core.
   wire        romSel;          // Decoded ROM service for a new cycle.
   wire        wbReq;           // Wishbone strobe.

   assign extBuild = ctrl_q[`RBO_CTRL_EXT_BIT];
   assign fullCore = ctrl_q[`RBO_CTRL_FULL_BIT];
   assign loadPress = loadStartSwitch & ~loadPrev_q;
   assign overlayActive = active_q;
   assign wbReq = wb_cyc_i & wb_stb_i;

   // Decides whether a new cycle is answered by the ROM.
   function romRoute;
      input          act;
      input          fetch;
      input          wr;
      input          full;
      input [AW-1:0] a;
      begin
         // Fetches in the low 128 words go to ROM only while loading.
         romRoute = (act & fetch & (a[AW-1:`RBO_ROM_AW] == 0)) |  // RQ6 RQ13
                    // Diagnostic read window exists only on small-core machines.
                    (~fetch & ~wr & ~full & (a >= `RBO_DIAG_BASE));  // RQ9 RQ11
      end
   endfunction

   assign romSel = romRoute(active_q, cpuFetch, cpuWrite, fullCore, cpuAddr);

   // Core sees every cycle the ROM does not serve, data cycles to low memory included.
   assign coreReq   = (state_q == ST_CORE);  // RQ6 RQ12
   assign coreWrite = cpuWrite;
   assign coreAddr  = addr_q;

   rbo_rom #(
      .AW(`RBO_ROM_AW),
      .DW(DW)
   ) u_rom (
      .clock(clock),
      .addr (addr_q[`RBO_ROM_AW-1:0]),  // RQ9
      .data (romData)
   );

   // Panel handling: start only when stopped, flag the console only while running.
   always @(posedge clock) begin
      if (!rst_n) begin
         loadPrev_q       <= 1'b0;
         restartRequest   <= 1'b0;
         consoleInterrupt <= 1'b0;
         loadDevice       <= `RBO_DEV_TTY;
      end else begin
         loadPrev_q       <= loadStartSwitch;
         // Without the restart logic present the option stays inert.
         restartRequest   <= loadPress & restartPresent & stopSwitchUp & ~runMode;  // RQ1 RQ4 RQ5
         consoleInterrupt <= loadPress & runMode;  // RQ2
         if (loadPress & restartPresent & stopSwitchUp & ~runMode) begin
            // Lowest switch down wins if several are down.
            if (dataSwitchesDown[0]) begin  // RQ3
               loadDevice <= `RBO_DEV_FASTPT;
            end else if (dataSwitchesDown[1]) begin
               loadDevice <= `RBO_DEV_MAGTAPE;
            end else if (dataSwitchesDown[2]) begin
               loadDevice <= `RBO_DEV_CASSETTE;
            end else if (dataSwitchesDown[3]) begin
               loadDevice <= `RBO_DEV_DISK;
            end else begin
               loadDevice <= `RBO_DEV_TTY;
            end
         end
      end
   end

   // Overlay flag: set on entry, cleared when the terminal ROM fetch completes.
   always @(posedge clock) begin
      if (!rst_n) begin
         active_q <= 1'b0;
      end else if (loadPress & restartPresent & stopSwitchUp & ~runMode) begin
         active_q <= 1'b1;  // RQ4
      end else if (state_q == ST_ROMOUT && endHit_q) begin
         active_q <= 1'b0;  // RQ7 RQ8 RQ13
      end
   end

   // Next state of the memory cycle sequencer.
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            // A request still standing in its own acknowledge cycle is not taken again.
            if (cpuReq && !cpuAck) begin
               state_d = romSel ? ST_ROM : ST_CORE;
            end
         end
         ST_ROM: begin
            state_d = ST_ROMOUT;
         end
         ST_CORE: begin
            if (coreAck) begin
               state_d = ST_IDLE;
            end
         end
         ST_ROMOUT: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Cycle sequencer with latched address and answer path.
   always @(posedge clock) begin
      if (!rst_n) begin
         state_q    <= ST_IDLE;
         isRom_q    <= 1'b0;
         endHit_q   <= 1'b0;
         addr_q     <= {AW{1'b0}};
         cpuAck     <= 1'b0;
         cpuRdata   <= {DW{1'b0}};
         cpuFromRom <= 1'b0;
      end else begin
         state_q <= state_d;
         cpuAck  <= 1'b0;
         if (state_q == ST_IDLE && cpuReq && !cpuAck) begin
            addr_q   <= cpuAddr;
            isRom_q  <= romSel;
            // Terminal address depends on the build option.
            endHit_q <= cpuFetch & romSel &
                        (cpuAddr == (extBuild ? `RBO_END_EXT : `RBO_END_STD));  // RQ7 RQ8
         end
         if (state_q == ST_ROMOUT) begin
            cpuAck     <= 1'b1;
            // Byte-mode reads of the window get the whole word; software must not use them.
            cpuRdata   <= romData;  // RQ10
            cpuFromRom <= 1'b1;
         end else if (state_q == ST_CORE && coreAck) begin
            cpuAck     <= 1'b1;
            cpuRdata   <= coreRdata;
            cpuFromRom <= 1'b0;
         end
      end
   end

   // Wishbone slave: build option control and status, one wait state.
   always @(posedge clock) begin
      if (!rst_n) begin
         ctrl_q   <= `RBO_CTRL_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wbReq & ~wb_ack_o;
         if (wbReq && !wb_ack_o) begin
            if (wb_we_i && wb_adr_i == `RBO_WB_CTRL && wb_sel_i[0]) begin
               ctrl_q <= wb_dat_i[1:0];
            end
            case (wb_adr_i)
               `RBO_WB_CTRL: wb_dat_o <= {30'h00000000, ctrl_q};
               `RBO_WB_STAT: wb_dat_o <= {26'h0000000, isRom_q, loadDevice,
                                          restartPresent, active_q};
               default:      wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// ---- verilog/rbo_rom.v ----
// Loader ROM storage of the bootstrap overlay.
`timescale 1ns/1ps
`include "rbo_consts.vh"
module rbo_rom #(
   parameter AW = `RBO_ROM_AW,  // Word address width.
   parameter DW = `RBO_DATA_W   // Word width.
) (
   input  wire          clock,
   input  wire [AW-1:0] addr,
   output reg  [DW-1:0] data
);
   // Contents are a plain default image; a real loader image replaces the table.
   reg [DW-1:0] mem [0:(1<<AW)-1];  // Loader words.
   integer i;                       // Fill index.

   // Default image: each word holds its own address, which a diagnostic can verify.
   initial begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
         mem[i] = i[DW-1:0];
      end
   end

   // Registered read, one cycle of latency.
   always @(posedge clock) begin
      data <= mem[addr];
   end
endmodule
